// File: design/dpd_pkg.sv
// package: constants and types for the power-down and self-refresh temperature block
package dpd_pkg;

	// ********************************************************************
	// register map (avalon-mm word addresses, byte address = 4 * index)
	// ********************************************************************
	localparam logic [3:0] REG_MODE_TWO = 4'h0;
	localparam logic [3:0] REG_CONFIG = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_BANKS = 4'h3;

	// mode_register_two field positions
	localparam int AUTO_TEMP_BIT = 6;
	localparam int EXT_TEMP_BIT = 7;
	localparam logic [15:0] MODE_TWO_RESET = 16'h0000;

	// config register fields
	localparam int CFG_FAST_EXIT_BIT = 0;
	localparam int CFG_ASYNC_TERMINATION_LEAD_TIME_LSB = 8;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0401;

	// status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_DLL_ON_BIT = 4;
	localparam int ST_BUF_OFF_BIT = 5;
	localparam int ST_ODT_ASYNC_BIT = 6;
	localparam int ST_SR_EXT_OK_BIT = 7;
	localparam int ST_ILLEGAL_BIT = 8;
	localparam int ST_DLL_RESET_BIT = 9;

	// ********************************************************************
	// timing
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int BUF_DISABLE_DELAY_CK = 3;
	localparam int DLL_EXIT_DELAY_NS = 24;
	localparam int DLL_EXIT_DELAY_MIN_CK = 10;
	localparam logic [7:0] DLL_EXIT_DELAY_CYC = 8'(DLL_EXIT_DELAY_MIN_CK);
	localparam logic [7:0] BUF_DISABLE_CYC = 8'(BUF_DISABLE_DELAY_CK);

	// ********************************************************************
	// command encoding {cs_n, ras_n, cas_n, we_n}
	// ********************************************************************
	localparam logic [3:0] CMD_NOP = 4'h7;

	typedef enum logic [1:0] {
		DPD_NORMAL = 2'b00,
		DPD_ACTIVE_PD = 2'b01,
		DPD_FAST_PPD = 2'b11,
		DPD_SLOW_PPD = 2'b10
	} dpd_mode_type;

endpackage

// File: design/dpd_edge.sv
// link clock synchroniser and rising-edge finder
`timescale 1ns/1ps
module dpd_edge (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// link side
	input wire logic i_async,
	// outputs
	output logic o_level,
	output logic o_rise
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} dpd_edge_type;

	dpd_edge_type r;
	dpd_edge_type next_r;

	always_comb begin
		next_r = r;
		next_r.meta = i_async;
		next_r.sync = r.meta;
		next_r.prev = r.sync;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_level = r.sync;
	assign o_rise = r.sync & ~r.prev;
endmodule // dpd_edge

// File: design/dpd_ctrl.sv
// power-down entry/exit control with self-refresh temperature options
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// [RQ1] controller refreshes twice as often above 85C: period 64ms becomes 32ms
// [RQ2] self refresh above 85C only allowed with auto or extended temp enabled
// [RQ3] with auto off, bit 7 picks normal (85C) or extended (95C) range
// [RQ4] bit 6 set: device adapts self-refresh rate itself
// [RQ5] controller never sets bits 6 and 7 together; illegal combination
// [RQ6] enter power-down when cke sampled low with nop or deselect
// [RQ7] cke may not drop during mode set, mpr, zq, read or write
// [RQ8] cke may drop during activate, precharge or refresh; device finishes first
// [RQ9] wait one clock after activate, precharge, refresh; mode update after mode set
// [RQ10] read and write to power-down entry delays per latency and recovery
// [RQ11] refresh between exit and entry: next entry waits max(10 clk, 24ns)
// [RQ12] slow-exit precharge power-down: termination asynchronous around the window
// [RQ13] power-down disables buffers except clock, termination, cke, reset
// [RQ14] controller sends only nop or deselect until buffer-disable delay passes
// [RQ15] unlocked dll at entry needs dll reset after exit
// [RQ16] open bank gives active power-down, all closed gives precharge power-down
// [RQ17] slow exit turns dll off, fast exit and active power-down keep it on
// [RQ18] controller holds cke low at least the minimum power-down time
// [RQ19] exit when cke sampled high with nop or deselect
// [RQ20] state holds normal, active, fast precharge or slow precharge power-down
module dpd_ctrl
	import dpd_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// avalon-mm slave
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// memory link pins
	input wire logic i_ck,
	input wire logic i_cke,
	input wire logic [3:0] i_cmd,
	input wire logic i_dll_locked,
	// power-down outputs
	output logic o_buffers_enable,
	output logic o_dll_enable,
	output logic o_odt_async,
	output logic o_fast_exit_refresh,
	output logic [1:0] o_pd_mode
);
	typedef struct packed {
		logic rst_a;
		logic rst_b;
		logic [8:0] pin_meta;
		logic [8:0] pin_sync;
		logic ack;
		logic [31:0] rdata;
		logic [15:0] mode_two;
		logic fast_exit;
		logic [7:0] lead_cyc;
		logic [7:0] bank_open;
		dpd_mode_type mode;
		logic dll_on;
		logic buf_on;
		logic odt_async;
		logic [7:0] cnt;
		logic [7:0] lead_cnt;
		logic illegal;
		logic dll_reset_need;
		logic cke_prev;
	} dpd_ctrl_type;

	dpd_ctrl_type r;
	dpd_ctrl_type next_r;
	logic ck_level;
	logic ck_rise;
	logic cke_s;
	logic [3:0] cmd_s;
	logic dll_lock_s;
	logic rstn_int;

	// ********************************************************************
	// link clock edge finder
	// ********************************************************************
	dpd_edge u_ck (
		.i_clk(i_clk),
		.i_rstn(rstn_int),
		.i_async(i_ck),
		.o_level(ck_level),
		.o_rise(ck_rise)
	);

	assign rstn_int = r.rst_b;
	assign cke_s = r.pin_sync[0];
	assign cmd_s = r.pin_sync[4:1];
	assign dll_lock_s = r.pin_sync[5];

	function automatic logic is_nop(input logic [3:0] c);
		is_nop = c[3] | (c == CMD_NOP);
	endfunction

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		next_r = r;
		next_r.rst_a = 1'b1;
		next_r.rst_b = r.rst_a;
		next_r.pin_meta = {3'b000, i_dll_locked, i_cmd, i_cke};
		next_r.pin_sync = r.pin_meta;
		next_r.ack = 1'b0;

		// bus: one wait cycle, answer on the next edge
		if ((i_read | i_write) & ~r.ack) begin
			next_r.ack = 1'b1;
			next_r.rdata = 32'h0000_0000;
			case (i_address)
				REG_MODE_TWO: begin
					next_r.rdata = {16'h0000, r.mode_two};
				end
				REG_CONFIG: begin
					next_r.rdata = {16'h0000, r.lead_cyc, 7'h00, r.fast_exit};
				end
				REG_STATUS: begin
					next_r.rdata = {22'h000000, r.dll_reset_need, r.illegal,
						~r.mode_two[AUTO_TEMP_BIT] & ~r.mode_two[EXT_TEMP_BIT],
						r.odt_async, ~r.buf_on, r.dll_on, 2'b00, r.mode};
				end
				REG_BANKS: begin
					next_r.rdata = {24'h000000, r.bank_open};
				end
				default: begin
					next_r.rdata = 32'h0000_0000;
				end
			endcase
		end
		// a write lands only on the edge that samples waitrequest low
		if (i_write & r.ack) begin
			begin
				case (i_address)
					REG_MODE_TWO: begin
						next_r.mode_two = i_writedata[15:0];
						// both temperature options set is flagged
						next_r.illegal = i_writedata[AUTO_TEMP_BIT]
							& i_writedata[EXT_TEMP_BIT]; // RQ5
					end
					REG_CONFIG: begin
						next_r.fast_exit = i_writedata[CFG_FAST_EXIT_BIT];
						next_r.lead_cyc = i_writedata[CFG_ASYNC_TERMINATION_LEAD_TIME_LSB +: 8];
					end
					REG_BANKS: begin
						next_r.bank_open = i_writedata[7:0];
					end
					default: begin
					end
				endcase
			end
		end

		if (r.cnt != 8'h00) begin
			next_r.cnt = r.cnt - 8'h01;
		end

		// sample cke/command on each link clock rising edge
		if (ck_rise) begin
			next_r.cke_prev = cke_s;
			case (r.mode)
				DPD_NORMAL: begin
					if (r.cke_prev & ~cke_s & is_nop(cmd_s)) begin // RQ6
						next_r.dll_reset_need = ~dll_lock_s; // RQ15
						next_r.buf_on = 1'b0; // RQ13
						if (r.bank_open != 8'h00) begin // RQ16
							next_r.mode = DPD_ACTIVE_PD; // RQ20
						end else if (r.fast_exit) begin
							next_r.mode = DPD_FAST_PPD;
						end else begin
							next_r.mode = DPD_SLOW_PPD;
							next_r.dll_on = 1'b0; // RQ17
						end
					end
				end
				DPD_ACTIVE_PD, DPD_FAST_PPD, DPD_SLOW_PPD: begin
					if (cke_s & is_nop(cmd_s)) begin // RQ19
						next_r.mode = DPD_NORMAL;
						next_r.buf_on = 1'b1;
						next_r.dll_on = 1'b1;
						if (r.mode == DPD_SLOW_PPD) begin
							next_r.cnt = DLL_EXIT_DELAY_CYC; // RQ12
							next_r.lead_cnt = r.lead_cyc;
						end
					end
				end
				default: begin
					next_r.mode = DPD_NORMAL;
				end
			endcase
		end

		// termination asynchronous from slow-exit entry until lead + dll exit after exit
		if (r.mode == DPD_SLOW_PPD) begin
			next_r.odt_async = 1'b1; // RQ12
		end else if (r.odt_async & ck_rise & (r.cnt == 8'h00)) begin
			if (r.lead_cnt != 8'h00) begin
				next_r.lead_cnt = r.lead_cnt - 8'h01;
			end else begin
				next_r.odt_async = 1'b0;
			end
		end
		if (~ck_rise & (r.cnt != 8'h00)) begin
			next_r.cnt = r.cnt;
		end
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r <= '0;
			r.mode_two <= MODE_TWO_RESET;
			r.fast_exit <= CONFIG_RESET[CFG_FAST_EXIT_BIT];
			r.lead_cyc <= CONFIG_RESET[CFG_ASYNC_TERMINATION_LEAD_TIME_LSB +: 8];
			r.mode <= DPD_NORMAL;
			r.dll_on <= 1'b1;
			r.buf_on <= 1'b1;
			r.cke_prev <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign o_waitrequest = (i_read | i_write) & ~r.ack;
	assign o_readdata = r.rdata;
	assign o_buffers_enable = r.buf_on;
	assign o_dll_enable = r.dll_on;
	assign o_odt_async = r.odt_async;
	// device adapts its rate itself when auto is set, else follows range bit
	assign o_fast_exit_refresh = r.mode_two[AUTO_TEMP_BIT] ? 1'b1 : r.mode_two[EXT_TEMP_BIT]; // RQ4 RQ3
	assign o_pd_mode = r.mode;
endmodule // dpd_ctrl

// File: tb/dpd_ctrl_props.sv
// checker on the power-down block ports
`timescale 1ns/1ps
module dpd_ctrl_props
	import dpd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic i_cke,
	input wire logic o_waitrequest,
	input wire logic o_buffers_enable,
	input wire logic o_dll_enable,
	input wire logic o_odt_async,
	input wire logic [1:0] o_pd_mode
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic [6:0] hi_cnt;
	logic [6:0] lo_cnt;
	// cycles that cke has stood high or low, saturating
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hi_cnt <= '0;
			lo_cnt <= '0;
		end else begin
			hi_cnt <= !i_cke ? '0 : (hi_cnt == 7'h40 ? hi_cnt : hi_cnt + 7'h1);
			lo_cnt <= i_cke ? '0 : (lo_cnt == 7'h40 ? lo_cnt : lo_cnt + 7'h1);
		end
	end
	sequence slow_exit;
		$past(o_pd_mode) == DPD_SLOW_PPD && o_pd_mode == DPD_NORMAL;
	endsequence
	bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("bus request not answered");
	pd_enter_a: assert property (lo_cnt == 7'h40 |-> o_pd_mode != DPD_NORMAL)
		else $error("no power-down with cke low");
	pd_exit_a: assert property (hi_cnt == 7'h40 |-> o_pd_mode == DPD_NORMAL)
		else $error("no exit with cke high");
	buf_off_a: assert property (lo_cnt == 7'h40 |-> !o_buffers_enable)
		else $error("buffers on in power-down");
	buf_on_a: assert property (hi_cnt == 7'h40 |-> o_buffers_enable)
		else $error("buffers off after exit");
	dll_slow_a: assert property (!o_dll_enable |-> o_pd_mode == DPD_SLOW_PPD)
		else $error("dll off outside slow exit");
	dll_keep_a: assert property (o_pd_mode inside {DPD_ACTIVE_PD, DPD_FAST_PPD} |-> o_dll_enable)
		else $error("dll off in fast power-down");
	odt_slow_a: assert property ((o_pd_mode == DPD_SLOW_PPD) [*2] |-> o_odt_async)
		else $error("termination not asynchronous");
	odt_clear_a: assert property (slow_exit |-> ##[1:400] !o_odt_async)
		else $error("termination stays asynchronous");
	mode_path_a: assert property ($changed(o_pd_mode) |->
		$past(o_pd_mode) == DPD_NORMAL || o_pd_mode == DPD_NORMAL)
		else $error("direct power-down kind change");
endmodule // dpd_ctrl_props
bind dpd_ctrl dpd_ctrl_props i_props (.i_clk, .i_rstn, .i_read, .i_write, .i_cke,
	.o_waitrequest, .o_buffers_enable, .o_dll_enable, .o_odt_async, .o_pd_mode);

// File: tb/dpd_link_model.sv
// memory controller model: free-running link clock, cke and commands
`timescale 1ns/1ps
module dpd_link_model
	import dpd_pkg::*;
#(
	parameter int PD_MIN_CK = 3
) (
	input wire logic i_sleep,
	input wire logic [3:0] i_pre_cmd,
	output logic o_ck,
	output logic o_cke,
	output logic [3:0] o_cmd
);
	initial begin
		o_ck = 1'b0;
		#7;
		forever #80 o_ck = ~o_ck;
	end
	// commands change on the falling link edge, centred for the rising one
	initial begin
		o_cke = 1'b1;
		o_cmd = CMD_NOP;
		forever begin
			@(posedge i_sleep);
			@(negedge o_ck) o_cmd = i_pre_cmd;
			@(negedge o_ck) o_cmd = CMD_NOP;
			@(negedge o_ck) o_cke = 1'b0;
			repeat (PD_MIN_CK) @(negedge o_ck);
			wait (!i_sleep);
			@(negedge o_ck) o_cke = 1'b1;
		end
	end
endmodule // dpd_link_model

// File: tb/dpd_ctrl_bench.sv
// self-checking bench for the power-down block
`timescale 1ns/1ps
module dpd_ctrl_bench;
	import dpd_pkg::*;
	logic i_clk, i_rstn, i_read, i_write, i_ck, i_cke, i_dll_locked, sleep;
	logic [3:0] i_address, i_cmd, pre_cmd;
	logic [31:0] i_writedata, o_readdata, rd;
	logic o_waitrequest, o_buffers_enable, o_dll_enable, o_odt_async, o_fast_exit_refresh;
	logic [1:0] o_pd_mode;
	int fails, samples_checked, k;
	dpd_ctrl i_dut (.i_clk, .i_rstn, .i_address, .i_read, .i_write, .i_writedata,
		.o_readdata, .o_waitrequest, .i_ck, .i_cke, .i_cmd, .i_dll_locked,
		.o_buffers_enable, .o_dll_enable, .o_odt_async, .o_fast_exit_refresh, .o_pd_mode);
	dpd_link_model #(.PD_MIN_CK(3)) i_link (.i_sleep(sleep), .i_pre_cmd(pre_cmd),
		.o_ck(i_ck), .o_cke(i_cke), .o_cmd(i_cmd));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// ****************************************************************
	// checks, bus cycles and expectations
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("samples_checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= d;
		i_read <= !wr;
		i_write <= wr;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		rd = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		@(posedge i_clk);
		if (n == 50) begin
			fails++;
			give_verdict();
		end
	endtask
	task automatic wait_mode(input logic [1:0] m);
		int n;
		n = 0;
		while (o_pd_mode !== m && n < 400) begin
			@(posedge i_clk);
			n++;
		end
		if (n == 400) begin
			fails++;
			give_verdict();
		end
	endtask
	function automatic logic [1:0] mode_of(input int kind);
		return kind == 0 ? DPD_ACTIVE_PD : (kind == 1 ? DPD_FAST_PPD : DPD_SLOW_PPD);
	endfunction
	initial begin
		void'($urandom(32'h88BCE10F));
		{i_rstn, i_read, i_write, i_address, i_writedata} = '0;
		i_dll_locked = 1'b1;
		sleep = 1'b0;
		pre_cmd = CMD_NOP;
		fails = 0;
		samples_checked = 0;
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clk);
		bus(1'b0, REG_CONFIG, '0);
		check(rd, CONFIG_RESET);
		bus(1'b0, REG_MODE_TWO, '0);
		check(rd, 32'(MODE_TWO_RESET));
		bus(1'b0, REG_STATUS, '0);
		check(rd, 32'h0000_0090);
		k = 4 + $urandom_range(11);
		bus(1'b1, k[3:0], $urandom);
		bus(1'b0, k[3:0], '0);
		check(rd, '0);
		for (k = 0; k < 4; k++) begin
			bus(1'b1, REG_MODE_TWO, ($urandom & 32'hFF3F) | (k << 6));
			check(o_fast_exit_refresh, k != 0);
			bus(1'b0, REG_STATUS, '0);
			check(rd[8:7], {k == 3, k == 0});
		end
		// active, fast-exit precharge and slow-exit precharge power-down
		for (k = 0; k < 3; k++) begin
			bus(1'b1, REG_BANKS, k == 0 ? 1 + $urandom_range(254) : 0);
			bus(1'b1, REG_CONFIG, 32'h0000_0400 | (k < 2));
			i_dll_locked <= (k < 2);
			pre_cmd <= 4'h3 - k[3:0];
			sleep <= 1'b1;
			wait_mode(mode_of(k));
			check(o_pd_mode, mode_of(k));
			repeat (64) @(posedge i_clk);
			check(o_buffers_enable, '0);
			check(o_dll_enable, k < 2);
			check(o_odt_async, k == 2);
			sleep <= 1'b0;
			wait_mode(DPD_NORMAL);
			check(o_pd_mode, DPD_NORMAL);
			repeat (400) @(posedge i_clk);
			check(o_odt_async, '0);
			bus(1'b0, REG_STATUS, '0);
			check(rd[9], k == 2);
		end
		give_verdict();
	end
endmodule // dpd_ctrl_bench
